/* File: verilog/ecphs_defines.svh */
`ifndef ECPHS_DEFINES_SVH
`define ECPHS_DEFINES_SVH

`define ECPHS_CLK_PER_NS      10
`define ECPHS_CNT_W           8

// input stability window, stable for 75 to 130 ns
`define ECPHS_T_FILT_MIN_NS   75
`define ECPHS_T_FILT_MAX_NS   130
`define ECPHS_FILT_CYC        (((`ECPHS_T_FILT_MIN_NS + `ECPHS_T_FILT_MAX_NS) / 2) / `ECPHS_CLK_PER_NS)

// extended-mode response delay, 80 ns least, 180 ns most
`define ECPHS_T_RESP_MIN_NS   80
`define ECPHS_T_RESP_MAX_NS   180
`define ECPHS_RESP_CYC        ((`ECPHS_T_RESP_MIN_NS + `ECPHS_CLK_PER_NS - 1) / `ECPHS_CLK_PER_NS + 2)

// compatible fifo mode
`define ECPHS_T_SETUP_NS      600
`define ECPHS_T_WIDTH_NS      600
`define ECPHS_T_HOLD_NS       450
`define ECPHS_T_BUSY_HOLD_NS  80
`define ECPHS_T_GAP_NS        680
`define ECPHS_SETUP_CYC       ((`ECPHS_T_SETUP_NS + `ECPHS_CLK_PER_NS - 1) / `ECPHS_CLK_PER_NS)
`define ECPHS_WIDTH_CYC       ((`ECPHS_T_WIDTH_NS + `ECPHS_CLK_PER_NS - 1) / `ECPHS_CLK_PER_NS)
`define ECPHS_HOLD_CYC        ((`ECPHS_T_HOLD_NS + `ECPHS_CLK_PER_NS - 1) / `ECPHS_CLK_PER_NS)
`define ECPHS_BHOLD_CYC       ((`ECPHS_T_BUSY_HOLD_NS + `ECPHS_CLK_PER_NS - 1) / `ECPHS_CLK_PER_NS)
`define ECPHS_GAP_CYC         ((`ECPHS_T_GAP_NS + `ECPHS_CLK_PER_NS - 1) / `ECPHS_CLK_PER_NS)

`define ECPHS_DATA_RST        8'h00

`endif

/* File: verilog/ecphs_pkg.sv */
package ecphs_pkg;

   typedef enum logic [1:0]
   {
      ECPHS_MODE_COMPAT = 2'h0,
      ECPHS_MODE_FWD    = 2'h1,
      ECPHS_MODE_REV    = 2'h2
   } ecphs_mode_t;

   typedef enum logic [3:0]
   {
      ST_IDLE,
      ST_C_SETUP,
      ST_C_STROBE,
      ST_C_HOLD,
      ST_C_GAP,
      ST_F_ACK,
      ST_F_REL,
      ST_R_WAIT,
      ST_R_REL
   } ecphs_state_t;

endpackage

/* File: verilog/ecphs_buf.sv */
`timescale 1ns/10ps
module ecphs_buf
(
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       in_valid_i,
   output logic            in_ready_o,
   input  wire logic [7:0] in_data_i,
   output logic            out_valid_o,
   input  wire logic       out_ready_i,
   output logic [7:0]      out_data_o
);

   logic [7:0] mem_q [2];
   logic [7:0] mem_d [2];
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       wr_ptr_q;
   logic       wr_ptr_d;
   logic       rd_ptr_q;
   logic       rd_ptr_d;
   logic       push;
   logic       pop;

   assign in_ready_o  = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o  = mem_q[rd_ptr_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb
   begin
      mem_d    = mem_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      cnt_d    = cnt_q;
      if (push)
      begin
         mem_d[wr_ptr_q] = in_data_i;
         wr_ptr_d        = ~wr_ptr_q;
      end
      if (pop)
         rd_ptr_d = ~rd_ptr_q;
      if (push && !pop)
         cnt_d = cnt_q + 2'h1;
      else if (pop && !push)
         cnt_d = cnt_q - 2'h1;
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         mem_q[0] <= 8'h00;
         mem_q[1] <= 8'h00;
         cnt_q    <= 2'h0;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
      end
      else
      begin
         mem_q    <= mem_d;
         cnt_q    <= cnt_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
      end
   end

endmodule

/* File: verilog/ecphs_engine.sv */
// Notes on behaviour
// - fifo mode: byte held until busy low and hold time, whichever later
// - fifo mode: with nothing pending, last byte stays on the lines
// - fifo mode: next strobe at least 680 ns after busy goes inactive
// - fifo mode: data unchanged at least 80 ns after busy inactive
// - forward: autofd and data valid within 60 ns of strobe asserted
// - forward: autofd and data change 80 to 180 ns after busy low seen
// - forward: next strobe 80 to 200 ns after busy low seen
// - forward: strobe released 80 to 180 ns after busy high seen
// - forward: upper limits only with data waiting; empty means wait
// - busy counts only after stable 75 to 130 ns
// - reverse: autofd released 80 to 200 ns after ack low seen
// - reverse: autofd reasserted 80 to 200 ns after ack high seen
// - reverse: no room or terminal count stalls with autofd low
// - ack counts only after stable 75 to 130 ns
// - fifo mode ignores ack, paces on busy only
// - forward idle keeps strobe high
// - switch to active drive without glitches
`timescale 1ns/10ps
`include "ecphs_defines.svh"
module ecphs_engine
(
   input  wire logic                      ref_clk_i,
   input  wire logic                      resetn_i,
   input  wire ecphs_pkg::ecphs_mode_t    mode_i,
   input  wire logic                      tx_valid_i,
   output logic                           tx_ready_o,
   input  wire logic [7:0]                tx_data_i,
   input  wire logic                      tx_cmd_i,
   output logic                           rx_valid_o,
   input  wire logic                      rx_ready_i,
   output logic [7:0]                     rx_data_o,
   input  wire logic                      term_count_i,
   input  wire logic                      busy_i,
   input  wire logic                      ack_n_i,
   input  wire logic [7:0]                port_data_lines_i,
   output logic [7:0]                     port_data_lines_o,
   output logic                           port_data_lines_oe_o,
   output logic                           strobe_n_o,
   output logic                           strobe_oe_o,
   output logic                           autofd_n_o,
   output logic                           autofd_oe_o,
   output logic                           idle_o
);

   localparam logic [`ECPHS_CNT_W-1:0] FILT  = `ECPHS_CNT_W'(`ECPHS_FILT_CYC);
   localparam logic [`ECPHS_CNT_W-1:0] RESP  = `ECPHS_CNT_W'(`ECPHS_RESP_CYC);
   localparam logic [`ECPHS_CNT_W-1:0] SETUP = `ECPHS_CNT_W'(`ECPHS_SETUP_CYC);
   localparam logic [`ECPHS_CNT_W-1:0] WIDTH = `ECPHS_CNT_W'(`ECPHS_WIDTH_CYC);
   localparam logic [`ECPHS_CNT_W-1:0] HOLD  = `ECPHS_CNT_W'(`ECPHS_HOLD_CYC);
   localparam logic [`ECPHS_CNT_W-1:0] BHOLD = `ECPHS_CNT_W'(`ECPHS_BHOLD_CYC);
   localparam logic [`ECPHS_CNT_W-1:0] ONE   = `ECPHS_CNT_W'(1);

   // input filters: index 0 busy, index 1 ack
   logic                    raw     [2];
   logic                    sync1_q [2];
   logic                    sync2_q [2];
   logic                    flt_q   [2];
   logic                    flt_d   [2];
   logic [`ECPHS_CNT_W-1:0] fcnt_q  [2];
   logic [`ECPHS_CNT_W-1:0] fcnt_d  [2];
   logic                    busy_f;
   logic                    ack_f;

   assign raw[0] = busy_i;
   assign raw[1] = ack_n_i;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_filt
         always_comb
         begin
            flt_d[g]  = flt_q[g];
            fcnt_d[g] = '0;
            if (sync2_q[g] != flt_q[g])
            begin
               // level must differ for the full window before it counts
               if (fcnt_q[g] == FILT - ONE)
                  flt_d[g] = sync2_q[g];
               else
                  fcnt_d[g] = fcnt_q[g] + ONE;
            end
         end

         always_ff @(posedge ref_clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
            begin
               sync1_q[g] <= 1'b0;
               sync2_q[g] <= 1'b0;
               flt_q[g]   <= 1'b0;
               fcnt_q[g]  <= '0;
            end
            else
            begin
               sync1_q[g] <= raw[g];
               sync2_q[g] <= sync1_q[g];
               flt_q[g]   <= flt_d[g];
               fcnt_q[g]  <= fcnt_d[g];
            end
         end
      end
   endgenerate

   assign busy_f = flt_q[0];
   assign ack_f  = flt_q[1];

   ecphs_pkg::ecphs_state_t st_q;
   ecphs_pkg::ecphs_state_t st_d;
   ecphs_pkg::ecphs_mode_t  mode_q;
   ecphs_pkg::ecphs_mode_t  mode_d;
   logic [`ECPHS_CNT_W-1:0] cnt_q;
   logic [`ECPHS_CNT_W-1:0] cnt_d;
   logic [7:0]              data_q;
   logic [7:0]              data_d;
   logic                    strobe_n_q;
   logic                    strobe_n_d;
   logic                    autofd_n_q;
   logic                    autofd_n_d;
   logic                    drive_q;
   logic                    drive_d;
   logic                    doe_q;
   logic                    doe_d;
   logic                    ld;
   logic                    push;
   logic                    room;

   ecphs_buf u_rx_buf
   (
      .ref_clk_i   (ref_clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (push),
      .in_ready_o  (room),
      .in_data_i   (port_data_lines_i),
      .out_valid_o (rx_valid_o),
      .out_ready_i (rx_ready_i),
      .out_data_o  (rx_data_o)
   );

   always_comb
   begin
      st_d       = st_q;
      mode_d     = mode_q;
      cnt_d      = cnt_q;
      data_d     = data_q;
      strobe_n_d = strobe_n_q;
      autofd_n_d = autofd_n_q;
      drive_d    = drive_q;
      doe_d      = doe_q;
      ld         = 1'b0;
      push       = 1'b0;
      case (st_q)
         ecphs_pkg::ST_IDLE:
         begin
            // modes change only here, with strobe at rest; autofd may still be low from forward or reverse
            mode_d     = mode_i;
            cnt_d      = '0;
            strobe_n_d = 1'b1;
            // strobe already high and a low autofd is driven either way, so the driver swap cannot glitch
            drive_d    = (mode_q != ecphs_pkg::ECPHS_MODE_COMPAT);
            doe_d      = (mode_q != ecphs_pkg::ECPHS_MODE_REV);
            case (mode_q)
               ecphs_pkg::ECPHS_MODE_COMPAT:
               begin
                  autofd_n_d = 1'b1;
                  // ack is never looked at in this mode
                  if (tx_valid_i && !busy_f)
                  begin
                     ld     = 1'b1;
                     data_d = tx_data_i;
                     st_d   = ecphs_pkg::ST_C_SETUP;
                  end
               end
               ecphs_pkg::ECPHS_MODE_FWD:
               begin
                  if (tx_valid_i && !busy_f)
                  begin
                     ld         = 1'b1;
                     data_d     = tx_data_i;
                     autofd_n_d = ~tx_cmd_i;
                     strobe_n_d = 1'b0;
                     st_d       = ecphs_pkg::ST_F_ACK;
                  end
               end
               ecphs_pkg::ECPHS_MODE_REV:
               begin
                  autofd_n_d = 1'b0;
                  st_d       = ecphs_pkg::ST_R_WAIT;
               end
               default:
               begin
                  autofd_n_d = 1'b1;
               end
            endcase
         end
         ecphs_pkg::ST_C_SETUP:
         begin
            cnt_d = cnt_q + ONE;
            if (cnt_q == SETUP - ONE)
            begin
               cnt_d      = '0;
               strobe_n_d = 1'b0;
               st_d       = ecphs_pkg::ST_C_STROBE;
            end
         end
         ecphs_pkg::ST_C_STROBE:
         begin
            cnt_d = cnt_q + ONE;
            if (cnt_q == WIDTH - ONE)
            begin
               cnt_d      = '0;
               strobe_n_d = 1'b1;
               st_d       = ecphs_pkg::ST_C_HOLD;
            end
         end
         ecphs_pkg::ST_C_HOLD:
         begin
            if (cnt_q != HOLD - ONE)
               cnt_d = cnt_q + ONE;
            else if (!busy_f)
            begin
               cnt_d = '0;
               st_d  = ecphs_pkg::ST_C_GAP;
            end
         end
         ecphs_pkg::ST_C_GAP:
         begin
            // gap plus the next setup makes up the strobe spacing
            if (busy_f)
               cnt_d = '0;
            else if (cnt_q == BHOLD - ONE)
               st_d = ecphs_pkg::ST_IDLE;
            else
               cnt_d = cnt_q + ONE;
         end
         ecphs_pkg::ST_F_ACK:
         begin
            if (busy_f)
            begin
               cnt_d = cnt_q + ONE;
               if (cnt_q == RESP - ONE)
               begin
                  cnt_d      = '0;
                  strobe_n_d = 1'b1;
                  st_d       = ecphs_pkg::ST_F_REL;
               end
            end
         end
         ecphs_pkg::ST_F_REL:
         begin
            if (!busy_f)
            begin
               cnt_d = cnt_q + ONE;
               if (cnt_q == RESP - ONE)
                  st_d = ecphs_pkg::ST_IDLE;
            end
         end
         ecphs_pkg::ST_R_WAIT:
         begin
            // stalls with autofd low while full or at terminal count
            if (!ack_f && room && !term_count_i)
            begin
               if (cnt_q == RESP - ONE)
               begin
                  push       = 1'b1;
                  cnt_d      = '0;
                  autofd_n_d = 1'b1;
                  st_d       = ecphs_pkg::ST_R_REL;
               end
               else
                  cnt_d = cnt_q + ONE;
            end
         end
         ecphs_pkg::ST_R_REL:
         begin
            if (ack_f)
            begin
               cnt_d = cnt_q + ONE;
               if (cnt_q == RESP - ONE)
               begin
                  autofd_n_d = 1'b0;
                  st_d       = ecphs_pkg::ST_IDLE;
               end
            end
         end
         default:
         begin
            st_d = ecphs_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st_q       <= ecphs_pkg::ST_IDLE;
         mode_q     <= ecphs_pkg::ECPHS_MODE_COMPAT;
         cnt_q      <= '0;
         data_q     <= `ECPHS_DATA_RST;
         strobe_n_q <= 1'b1;
         autofd_n_q <= 1'b1;
         drive_q    <= 1'b0;
         doe_q      <= 1'b1;
      end
      else
      begin
         st_q       <= st_d;
         mode_q     <= mode_d;
         cnt_q      <= cnt_d;
         data_q     <= data_d;
         strobe_n_q <= strobe_n_d;
         autofd_n_q <= autofd_n_d;
         drive_q    <= drive_d;
         doe_q      <= doe_d;
      end
   end

   assign tx_ready_o           = ld;
   assign port_data_lines_o    = data_q;
   assign port_data_lines_oe_o = doe_q;
   // open-collector style: only pull low unless actively driving
   assign strobe_n_o           = strobe_n_q;
   assign strobe_oe_o          = drive_q || !strobe_n_q;
   assign autofd_n_o           = autofd_n_q;
   assign autofd_oe_o          = drive_q || !autofd_n_q;
   assign idle_o               = (st_q == ecphs_pkg::ST_IDLE);

   // helper: cycles since filtered busy went low, saturating
   // starts saturated: busy has been quiet since reset, first byte may go at once
   logic [7:0] busy_lo_q;
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         busy_lo_q <= 8'hff;
      else if (busy_f)
         busy_lo_q <= 8'h00;
      else if (busy_lo_q != 8'hff)
         busy_lo_q <= busy_lo_q + 8'h01;
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   property p_c_gap;
      $fell(strobe_n_q) && mode_q == ecphs_pkg::ECPHS_MODE_COMPAT |-> busy_lo_q >= 8'h44;
   endproperty
   a_c_gap: assert property (p_c_gap) else $error("strobe too soon after busy");

   property p_c_hold;
      $changed(data_q) && mode_q == ecphs_pkg::ECPHS_MODE_COMPAT |-> busy_lo_q >= 8'h08;
   endproperty
   a_c_hold: assert property (p_c_hold) else $error("data changed too early");

   property p_c_busy_hi;
      mode_q == ecphs_pkg::ECPHS_MODE_COMPAT && busy_f |=> $stable(data_q);
   endproperty
   a_c_busy_hi: assert property (p_c_busy_hi) else $error("data moved while busy");

   property p_idle_hold;
      st_q == ecphs_pkg::ST_IDLE && !tx_valid_i |=> $stable(data_q);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle data not held");

   property p_f_rel;
      st_q == ecphs_pkg::ST_F_ACK && $rose(busy_f) |-> ##10 $rose(strobe_n_q);
   endproperty
   a_f_rel: assert property (p_f_rel) else $error("strobe release timing");

   property p_f_data;
      $fell(strobe_n_q) && mode_q == ecphs_pkg::ECPHS_MODE_FWD |-> $past(ld);
   endproperty
   a_f_data: assert property (p_f_data) else $error("data not loaded with strobe");

   property p_f_idle;
      st_q == ecphs_pkg::ST_IDLE |-> strobe_n_q;
   endproperty
   a_f_idle: assert property (p_f_idle) else $error("strobe low in idle");

   property p_r_ack;
      st_q == ecphs_pkg::ST_R_WAIT && $fell(ack_f) && room && !term_count_i
         |-> !autofd_n_q [*8] ##1 !autofd_n_q ##1 !autofd_n_q
             ##1 (autofd_n_q || !room || term_count_i);
   endproperty
   a_r_ack: assert property (p_r_ack) else $error("autofd release timing");

   property p_r_stall;
      st_q == ecphs_pkg::ST_R_WAIT && (term_count_i || !room) |=> !autofd_n_q;
   endproperty
   a_r_stall: assert property (p_r_stall) else $error("stall not held");

   property p_filt;
      $changed(busy_f) |-> $past(sync2_q[0]) == busy_f && $past(fcnt_q[0]) == FILT - ONE;
   endproperty
   a_filt: assert property (p_filt) else $error("busy filter too short");

   c_compat: cover property ($rose(strobe_n_q) && mode_q == ecphs_pkg::ECPHS_MODE_COMPAT);
   c_fwd: cover property (st_q == ecphs_pkg::ST_F_REL ##1 st_q == ecphs_pkg::ST_IDLE);
   c_rev: cover property (push);
   c_stall: cover property (st_q == ecphs_pkg::ST_R_WAIT && !room);

endmodule

/* File: verification/ecphs_periph.sv */
`timescale 1ns/10ps
module ecphs_periph
(
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       strobe_n_i,
   input  wire logic       autofd_n_i,
   input  wire logic [7:0] data_i,
   input  wire logic       slow_i,
   input  wire logic       bounce_i,
   input  wire logic       rev_en_i,
   output logic            busy_o,
   output logic            ack_n_o,
   output logic [7:0]      data_o,
   output logic [7:0]      cap_o,
   output int              cap_cnt_o,
   output int              rev_cnt_o
);
   localparam logic [7:0] base = 8'h40;

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   task automatic dly();
      step(slow_i ? 40 : 3);
   endtask

   initial
   begin
      cap_cnt_o = 0;
      rev_cnt_o = 0;
      data_o = 8'h00;
   end

   always
   begin : proc
      if (!resetn_i)
      begin
         busy_o <= 1'b0;
         ack_n_o <= 1'b1;
         data_o <= ~data_o;
         wait (resetn_i);
      end
      @(posedge ref_clk_i);
      if (mode_i != ecphs_pkg::ECPHS_MODE_REV && !strobe_n_i)
      begin
         dly();
         if (bounce_i)
         begin
            busy_o <= 1'b1;
            step(4);
            busy_o <= 1'b0;
            step(4);
         end
         busy_o <= 1'b1;
         cap_o <= data_i;
         cap_cnt_o <= cap_cnt_o + 1;
         while (!strobe_n_i)
            @(posedge ref_clk_i);
         if (mode_i == ecphs_pkg::ECPHS_MODE_COMPAT)
         begin
            // long enough to pass any filter: fifo mode must not care
            ack_n_o <= 1'b0;
            step(20);
            ack_n_o <= 1'b1;
         end
         dly();
         busy_o <= 1'b0;
      end
      else if (mode_i == ecphs_pkg::ECPHS_MODE_REV && rev_en_i && !autofd_n_i)
      begin
         dly();
         data_o <= base + rev_cnt_o[7:0];
         step(1);
         if (bounce_i)
         begin
            ack_n_o <= 1'b0;
            step(4);
            ack_n_o <= 1'b1;
            step(4);
         end
         ack_n_o <= 1'b0;
         while (!autofd_n_i)
            @(posedge ref_clk_i);
         dly();
         ack_n_o <= 1'b1;
         data_o <= ~data_o;
         rev_cnt_o <= rev_cnt_o + 1;
      end
   end

   always @(negedge resetn_i)
      disable proc;
endmodule

/* File: verification/ecp_fifo_parallel_handshake_tb.sv */
`timescale 1ns/10ps
module ecp_fifo_parallel_handshake_tb;
   typedef struct packed
   {
      ecphs_pkg::ecphs_mode_t mode;
      logic [7:0]             data;
      logic                   cmd;
      logic                   slow;
      logic                   bounce;
   } ecphs_row_t;
   localparam ecphs_pkg::ecphs_mode_t mc = ecphs_pkg::ECPHS_MODE_COMPAT;
   localparam ecphs_pkg::ecphs_mode_t mf = ecphs_pkg::ECPHS_MODE_FWD;
   localparam ecphs_pkg::ecphs_mode_t mr = ecphs_pkg::ECPHS_MODE_REV;
   localparam int nolim = 1000000;
   localparam ecphs_row_t rows [8] = '{
      '{mc, 8'h5a, 1'b0, 1'b0, 1'b0}, '{mc, 8'ha5, 1'b0, 1'b1, 1'b0},
      '{mc, 8'hff, 1'b0, 1'b0, 1'b1}, '{mc, 8'h00, 1'b0, 1'b0, 1'b0},
      '{mf, 8'h3c, 1'b1, 1'b0, 1'b0}, '{mf, 8'hc3, 1'b0, 1'b1, 1'b0},
      '{mf, 8'h81, 1'b1, 1'b0, 1'b1}, '{mf, 8'h7e, 1'b0, 1'b0, 1'b0}};

   logic                   ref_clk_i = 1'b0;
   logic                   resetn_i = 1'b0;
   ecphs_pkg::ecphs_mode_t mode_i = mc;
   logic                   tx_valid_i = 1'b0;
   logic [7:0]             tx_data_i = 8'h00;
   logic                   tx_cmd_i = 1'b0;
   logic                   rx_ready_i = 1'b0;
   logic                   term_count_i = 1'b0;
   logic                   slow = 1'b0;
   logic                   bounce = 1'b0;
   logic                   rev_en = 1'b0;
   logic                   tx_ready_o, rx_valid_o, strobe_n_o, strobe_oe_o;
   logic                   autofd_n_o, autofd_oe_o, idle_o, busy_i, ack_n_i, data_oe;
   logic [7:0]             rx_data_o, port_data_lines_o, per_data, cap_d, last_d;
   logic                   last_c, pend, mon_en, bq, aq, sq, fq, swq, fwq;
   logic [7:0]             dq;
   int                     n_errors = 0, compares = 0, exp_cap = 0, exp_rev = 0;
   int                     cyc = 0, t_bh = -1000, t_bl = -1000, t_af = 0, t_ar = 0;
   int                     cap_cnt, rev_cnt;
   // open-collector strobe and autofd float high when not driven
   wire                    strobe_w = strobe_oe_o ? strobe_n_o : 1'b1;
   wire                    autofd_w = autofd_oe_o ? autofd_n_o : 1'b1;
   wire [7:0]              data_w = data_oe ? port_data_lines_o : per_data;

   always #5 ref_clk_i = ~ref_clk_i;

   ecphs_engine i_dut
   (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .mode_i(mode_i),
      .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i),
      .tx_cmd_i(tx_cmd_i), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
      .rx_data_o(rx_data_o), .term_count_i(term_count_i), .busy_i(busy_i),
      .ack_n_i(ack_n_i), .port_data_lines_i(data_w), .port_data_lines_o(port_data_lines_o),
      .port_data_lines_oe_o(data_oe), .strobe_n_o(strobe_n_o), .strobe_oe_o(strobe_oe_o),
      .autofd_n_o(autofd_n_o), .autofd_oe_o(autofd_oe_o), .idle_o(idle_o)
   );

   ecphs_periph i_per
   (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .mode_i(mode_i), .strobe_n_i(strobe_w),
      .autofd_n_i(autofd_w), .data_i(data_w), .slow_i(slow), .bounce_i(bounce),
      .rev_en_i(rev_en), .busy_o(busy_i), .ack_n_o(ack_n_i), .data_o(per_data),
      .cap_o(cap_d), .cap_cnt_o(cap_cnt), .rev_cnt_o(rev_cnt)
   );

   task automatic complete_run();
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int g, input int lo, input int hi);
      compares++;
      if (g < lo || g > hi)
      begin
         n_errors++;
         $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, g);
      end
   endtask

   function automatic logic sig(input int w);
      case (w)
         0: sig = idle_o;
         1: sig = autofd_n_o;
         2: sig = rx_valid_o;
         4: sig = (cap_cnt >= exp_cap);
         5: sig = (rev_cnt >= exp_rev);
         default: sig = tx_ready_o;
      endcase
   endfunction

   task automatic wait_lvl(input int w, input logic l, input int max);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (sig(w) !== l && n < max);
      if (sig(w) !== l)
      begin
         chk_rng("wait", n, 0, max - 1);
         complete_run();
      end
   endtask

   task automatic send(input logic [7:0] d, input logic c);
      @(posedge ref_clk_i);
      last_d = d;
      last_c = c;
      tx_valid_i <= 1'b1;
      tx_data_i <= d;
      tx_cmd_i <= c;
      wait_lvl(6, 1'b1, 3000);
      tx_valid_i <= 1'b0;
      exp_cap++;
      wait_lvl(4, 1'b1, 800);
      chk_val("cap_data", d, cap_d);
   endtask

   task automatic new_mode(input ecphs_pkg::ecphs_mode_t m);
      wait_lvl(0, 1'b1, 3000);
      pend = 1'b0;
      repeat (50) @(posedge ref_clk_i);
      chk_val("data_held", last_d, port_data_lines_o);
      chk_val("strobe_idle", 8'h01, {7'h0, strobe_n_o});
      mode_i <= m;
      repeat (3) @(posedge ref_clk_i);
   endtask

   task automatic chk_rst();
      chk_val("rst_data", 8'h00, port_data_lines_o);
      chk_val("rst_flags", 8'he4, {strobe_n_o, autofd_n_o, idle_o, tx_ready_o,
         rx_valid_o, data_oe, strobe_oe_o, autofd_oe_o});
   endtask

   task automatic rd(input logic [7:0] e);
      wait_lvl(2, 1'b1, 1500);
      chk_val("rx_data", e, rx_data_o);
      rx_ready_i <= 1'b1;
      @(posedge ref_clk_i);
      rx_ready_i <= 1'b0;
   endtask

   task automatic stall(input string nm);
      int n;
      n = 0;
      wait_lvl(1, 1'b0, 300);
      repeat (150)
      begin
         @(posedge ref_clk_i);
         n += (autofd_n_o !== 1'b0);
      end
      chk_rng(nm, n, 0, 0);
   endtask

   // edge timing measured from the pins, so filter time widens the window
   always @(posedge ref_clk_i)
   begin
      cyc++;
      t_bh = (busy_i && !bq) ? cyc : t_bh;
      t_bl = (!busy_i && bq) ? cyc : t_bl;
      t_af = (!ack_n_i && aq) ? cyc : t_af;
      t_ar = (ack_n_i && !aq) ? cyc : t_ar;
      if (mon_en && mode_i == mf && strobe_n_o && !sq)
         chk_rng("strobe_rel", cyc - t_bh, 15, 31);
      if (mon_en && !strobe_n_o && sq)
      begin
         chk_val("data_at_strobe", last_d, port_data_lines_o);
         if (mode_i == mc)
            chk_rng("strobe_gap", cyc - t_bl, 68, nolim);
         else
            chk_rng("strobe_next", cyc - t_bl, 15, pend ? 33 : nolim);
         if (mode_i == mf)
            chk_val("autofd_at_strobe", {7'h0, ~last_c}, {7'h0, autofd_n_o});
      end
      if (mon_en && mode_i != mr && port_data_lines_o !== dq)
         chk_rng("data_change", cyc - t_bl, (mode_i == mf) ? 15 : 8,
            (pend && mode_i == mf) ? 31 : nolim);
      if (mon_en && pend && mode_i == mr && autofd_n_o && !fq)
         chk_rng("autofd_rel", cyc - t_af, 15, 33);
      if (mon_en && pend && mode_i == mr && !autofd_n_o && fq)
         chk_rng("autofd_again", cyc - t_ar, 15, 33);
      if (mon_en && ((strobe_w !== swq && strobe_n_o === sq) ||
                     (autofd_w !== fwq && autofd_n_o === fq)))
         chk_rng("pin_glitch", 1, 0, 0);
      bq = busy_i;
      aq = ack_n_i;
      sq = strobe_n_o;
      fq = autofd_n_o;
      swq = strobe_w;
      fwq = autofd_w;
      dq = port_data_lines_o;
   end

   initial
   begin
      pend = 1'b0;
      mon_en = 1'b0;
      last_d = 8'h00;
      repeat (4) @(posedge ref_clk_i);
      chk_rst();
      resetn_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      mon_en = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         if (rows[i].mode !== mode_i)
            new_mode(rows[i].mode);
         slow <= rows[i].slow;
         bounce <= rows[i].bounce;
         send(rows[i].data, rows[i].cmd);
         pend = 1'b1;
      end
      new_mode(mr);
      slow <= 1'b0;
      bounce <= 1'b0;
      rev_en <= 1'b1;
      exp_rev = 2;
      wait_lvl(5, 1'b1, 1500);
      stall("stall_full");
      rd(8'h40);
      rd(8'h41);
      rd(8'h42);
      term_count_i <= 1'b1;
      stall("stall_term");
      term_count_i <= 1'b0;
      rd(8'h43);
      pend = 1'b1;
      bounce <= 1'b1;
      rd(8'h44);
      bounce <= 1'b0;
      slow <= 1'b1;
      rd(8'h45);
      rev_en <= 1'b0;
      mon_en = 1'b0;
      resetn_i <= 1'b0;
      mode_i <= mf;
      repeat (2) @(posedge ref_clk_i);
      chk_rst();
      resetn_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      pend = 1'b0;
      mon_en = 1'b1;
      send(8'h99, 1'b1);
      complete_run();
   end
endmodule
